/* File: hdl/nv_mem_pkg.sv */
// Purpose: Shared constants and carrier types for the two-wire memory slave.
// Assumes: A 250 MHz system clock and a separate link sampling clock.
// Notes: Field positions refer to the selection byte as it arrives, bit 7 first.
package nv_mem_pkg;

   // ***************************************************************
   // Array geometry
   // ***************************************************************
   localparam int MEM_BYTES = 65536;
   localparam int BANK_BYTES = 32768;
   localparam int ADDR_W = 16;
   localparam int LATCH_W = 15;
   localparam int FIFO_DEPTH = 8;

   // ***************************************************************
   // Selection byte layout
   // ***************************************************************
   localparam int SEL_TYPE_LSB = 4;
   localparam int SEL_PIN_HI_POS = 3;
   localparam int SEL_PIN_LO_POS = 2;
   localparam int SEL_BANK_POS = 1;
   localparam int SEL_RW_POS = 0;
   // Device type code; the value is arbitrary.
   localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // ***************************************************************
   // Bus timing
   // ***************************************************************
   localparam int SYS_CLK_MHZ = 250;
   localparam int SCL_MAX_KHZ = 1000;
   localparam int SCL_FAST_KHZ = 400;
   localparam int SCL_STD_KHZ = 100;
   // Shortest serial clock period in system cycles, rounded up.
   localparam int SCL_MIN_PERIOD_CYC = (SYS_CLK_MHZ * 1000 + SCL_MAX_KHZ - 1) / SCL_MAX_KHZ;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_rx = 3'b001,
      st_ack = 3'b010,
      st_tx = 3'b011,
      st_mack = 3'b100
   } link_st_t;

   typedef enum logic [1:0] {
      ph_sel = 2'b00,
      ph_hi = 2'b01,
      ph_lo = 2'b10,
      ph_data = 2'b11
   } rx_phase_t;

   typedef struct packed {
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } mem_cmd_t;

   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_d;
      logic sda_m;
      logic sda_s;
      logic sda_d;
      logic [1:0] sel_m;
      logic [1:0] sel_s;
      logic rdt_m;
      logic rdt_s;
      logic rdt_d;
      link_st_t st;
      rx_phase_t ph;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic rw;
      logic bank;
      logic [LATCH_W-1:0] addr;
      logic oe;
      logic drv;
      logic [7:0] rd_buf;
      logic push;
      mem_cmd_t cmd;
   } link_state_t;

   typedef struct packed {
      logic wp_m;
      logic wp_s;
      logic pend;
      logic fetch;
      logic we;
      logic rd_tgl;
      logic [7:0] rd_data;
      mem_cmd_t wcmd;
   } sys_state_t;

   // Pin copies start at the idle high level, so no false edge follows reset.
   localparam link_state_t LINK_RESET = link_state_t'({6'h3F, {($bits(link_state_t) - 6){1'b0}}});
   localparam sys_state_t SYS_RESET = '0;

endpackage

/* File: hdl/two_wire_nv_memory_slave.sv */
// Purpose: Two-wire serial byte memory slave with a 65,536 byte array.
// Assumes: link_clk oversamples the serial pins; clk_sys owns the array.
// Notes: Commands cross from link to system domain through an async FIFO.
//
// Operation
// (RULE1) The array holds 65,536 bytes of 8 bits, read and written over the serial bus.
// (RULE2) The array is two banks of 32,768 bytes, chosen by the bank bit of the selection byte.
// (RULE3) A selection byte plus address bytes form a 16-bit byte address.
// (RULE4) The device answers only when the select bits match its two select pins.
// (RULE5) While write protect is high no array location changes.
// (RULE6) While write protect is low every address may be written.
// (RULE7) Transmitted data changes only after a falling serial clock edge.
// (RULE8) Received bits are captured on the rising serial clock edge.
// (RULE9) The data line is only pulled low or released, never driven high.
// (RULE10) Each written byte is committed at bus speed with no busy period.
// (RULE11) Serial clocks up to 1 MHz and the 100 kHz and 400 kHz timings all work.
// (RULE12) Only the power-on reset initialises the interface logic.
// (RULE13) The selection byte holds type in bits 7-4, select in 3-2, bank in 1, read flag in 0.
// (RULE14) A write sends upper address (top bit ignored) then lower; 15 bits are latched.
// (RULE15) The address increments per byte and wraps within its own bank.
// (RULE16) Reads continue while the master acknowledges and end on its missing acknowledge.
// (RULE17) On a select mismatch the line stays released until the next start.
`timescale 1ns/1ps
`default_nettype none

// ***************************************************************
// Asynchronous FIFO with gray-coded pointers
// ***************************************************************
module nv_async_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic wr_clk,
   input wire logic rd_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic [AW:0] far_m;
      logic [AW:0] far_s;
   } ptr_side_t;

   ptr_side_t wr_ff, nxt_wr, rd_ff, nxt_rd;
   logic [WIDTH-1:0] slot_mem [0:DEPTH-1];
   logic [AW:0] wr_bin_inc, rd_bin_inc;

   // Full when the write pointer laps the synchronised read pointer.
   assign in_ready = wr_ff.gray != {~wr_ff.far_s[AW:AW-1], wr_ff.far_s[AW-2:0]};
   assign out_valid = rd_ff.gray != rd_ff.far_s;
   assign out_data = slot_mem[rd_ff.bin[AW-1:0]];
   assign wr_bin_inc = wr_ff.bin + 1'b1;
   assign rd_bin_inc = rd_ff.bin + 1'b1;

   // Write side pointer and synchroniser of the read pointer.
   always_comb begin
      nxt_wr = wr_ff;
      nxt_wr.far_m = rd_ff.gray;
      nxt_wr.far_s = wr_ff.far_m;
      if (in_valid && in_ready) begin
         nxt_wr.bin = wr_bin_inc;
         nxt_wr.gray = wr_bin_inc ^ (wr_bin_inc >> 1);
      end
   end

   // Read side pointer and synchroniser of the write pointer.
   always_comb begin
      nxt_rd = rd_ff;
      nxt_rd.far_m = wr_ff.gray;
      nxt_rd.far_s = rd_ff.far_m;
      if (out_valid && out_ready) begin
         nxt_rd.bin = rd_bin_inc;
         nxt_rd.gray = rd_bin_inc ^ (rd_bin_inc >> 1);
      end
   end

   // Write side registers and storage.
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
      end
   end

   always_ff @(posedge wr_clk) begin
      if (in_valid && in_ready) begin
         slot_mem[wr_ff.bin[AW-1:0]] <= in_data;
      end
   end

   // Read side registers.
   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         rd_ff <= '0;
      end else begin
         rd_ff <= nxt_rd;
      end
   end
endmodule

// ***************************************************************
// Memory slave top
// ***************************************************************
module two_wire_nv_memory_slave #(
   parameter logic [3:0] DEVICE_TYPE = nv_mem_pkg::DEV_TYPE_DEFAULT,
   parameter int FIFO_DEPTH = nv_mem_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic link_clk,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic device_select_pin_low,
   input wire logic device_select_pin_high,
   input wire logic write_protect
);
   nv_mem_pkg::link_state_t link_ff, nxt_link;
   nv_mem_pkg::sys_state_t sys_ff, nxt_sys;
   nv_mem_pkg::mem_cmd_t fifo_out_data;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready, pop;
   logic scl_rise, scl_fall, start_seen, stop_seen, rd_arrive, do_inc, byte_end, sel_match;
   logic [7:0] mem_q;
   logic [7:0] mem_array [0:nv_mem_pkg::MEM_BYTES-1]; // [RULE1]

   // Pin events seen on the synchronised copies; 1 MHz leaves many samples per bit. [RULE11]
   assign scl_rise = link_ff.scl_s & ~link_ff.scl_d;
   assign scl_fall = ~link_ff.scl_s & link_ff.scl_d;
   assign start_seen = link_ff.scl_s & link_ff.scl_d & link_ff.sda_d & ~link_ff.sda_s;
   assign stop_seen = link_ff.scl_s & link_ff.scl_d & ~link_ff.sda_d & link_ff.sda_s;
   assign rd_arrive = link_ff.rdt_s ^ link_ff.rdt_d;
   assign byte_end = scl_fall && (link_ff.cnt == nv_mem_pkg::BITS_PER_BYTE);
   assign sel_match = link_ff.sh[7:nv_mem_pkg::SEL_TYPE_LSB] == DEVICE_TYPE &&
      link_ff.sh[nv_mem_pkg::SEL_PIN_HI_POS:nv_mem_pkg::SEL_PIN_LO_POS] == link_ff.sel_s;

   // ***************************************************************
   // Link domain protocol engine
   // ***************************************************************
   always_comb begin
      nxt_link = link_ff;
      do_inc = 1'b0;
      nxt_link.scl_m = scl;
      nxt_link.scl_s = link_ff.scl_m;
      nxt_link.scl_d = link_ff.scl_s;
      nxt_link.sda_m = sda_in;
      nxt_link.sda_s = link_ff.sda_m;
      nxt_link.sda_d = link_ff.sda_s;
      nxt_link.sel_m = {device_select_pin_high, device_select_pin_low};
      nxt_link.sel_s = link_ff.sel_m;
      nxt_link.rdt_m = sys_ff.rd_tgl;
      nxt_link.rdt_s = link_ff.rdt_m;
      nxt_link.rdt_d = link_ff.rdt_s;
      nxt_link.push = 1'b0;
      nxt_link.drv = 1'b0; // The line is only ever pulled low. [RULE9]
      if (rd_arrive) begin
         nxt_link.rd_buf = sys_ff.rd_data;
      end
      if (start_seen) begin
         nxt_link.st = nv_mem_pkg::st_rx;
         nxt_link.ph = nv_mem_pkg::ph_sel;
         nxt_link.cnt = 4'h0;
         nxt_link.oe = 1'b0;
      end else if (stop_seen) begin
         nxt_link.st = nv_mem_pkg::st_idle;
         nxt_link.oe = 1'b0;
      end else begin
         case (link_ff.st)
            nv_mem_pkg::st_rx: begin
               if (scl_rise) begin
                  nxt_link.sh = {link_ff.sh[6:0], link_ff.sda_s}; // [RULE8]
                  nxt_link.cnt = 4'(link_ff.cnt + 1'b1);
               end else if (byte_end) begin
                  nxt_link.st = nv_mem_pkg::st_ack;
                  nxt_link.oe = 1'b1;
                  case (link_ff.ph)
                     nv_mem_pkg::ph_sel: begin
                        if (!sel_match) begin
                           nxt_link.st = nv_mem_pkg::st_idle; // [RULE4] [RULE17]
                           nxt_link.oe = 1'b0;
                        end else begin
                           nxt_link.bank = link_ff.sh[nv_mem_pkg::SEL_BANK_POS]; // [RULE2]
                           nxt_link.rw = link_ff.sh[nv_mem_pkg::SEL_RW_POS]; // [RULE13]
                           if (link_ff.sh[nv_mem_pkg::SEL_RW_POS]) begin
                              if (fifo_in_ready) begin
                                 nxt_link.push = 1'b1; // Fetch from the current address.
                                 nxt_link.cmd.rd = 1'b1;
                                 nxt_link.cmd.addr = {link_ff.sh[nv_mem_pkg::SEL_BANK_POS],
                                    link_ff.addr};
                                 nxt_link.cmd.data = 8'h00;
                                 do_inc = 1'b1;
                              end else begin
                                 nxt_link.st = nv_mem_pkg::st_idle;
                                 nxt_link.oe = 1'b0;
                              end
                           end
                        end
                     end
                     nv_mem_pkg::ph_hi: begin
                        nxt_link.addr[14:8] = link_ff.sh[6:0]; // [RULE14]
                     end
                     nv_mem_pkg::ph_lo: begin
                        nxt_link.addr[7:0] = link_ff.sh; // [RULE14]
                     end
                     default: begin
                        if (fifo_in_ready) begin
                           nxt_link.push = 1'b1; // Byte leaves at once, no busy time. [RULE10]
                           nxt_link.cmd.rd = 1'b0;
                           nxt_link.cmd.addr = {link_ff.bank, link_ff.addr}; // [RULE3]
                           nxt_link.cmd.data = link_ff.sh;
                           do_inc = 1'b1;
                        end else begin
                           nxt_link.st = nv_mem_pkg::st_idle;
                           nxt_link.oe = 1'b0;
                        end
                     end
                  endcase
               end
            end
            nv_mem_pkg::st_ack: begin
               if (scl_fall) begin
                  nxt_link.cnt = 4'h0;
                  if (link_ff.rw) begin
                     nxt_link.st = nv_mem_pkg::st_tx;
                     nxt_link.sh = link_ff.rd_buf;
                     nxt_link.oe = ~link_ff.rd_buf[7]; // [RULE7]
                  end else begin
                     nxt_link.st = nv_mem_pkg::st_rx;
                     nxt_link.oe = 1'b0;
                     if (link_ff.ph == nv_mem_pkg::ph_sel) begin
                        nxt_link.ph = nv_mem_pkg::ph_hi;
                     end else if (link_ff.ph == nv_mem_pkg::ph_hi) begin
                        nxt_link.ph = nv_mem_pkg::ph_lo;
                     end else begin
                        nxt_link.ph = nv_mem_pkg::ph_data;
                     end
                  end
               end
            end
            nv_mem_pkg::st_tx: begin
               if (scl_rise) begin
                  nxt_link.cnt = 4'(link_ff.cnt + 1'b1);
               end else if (byte_end) begin
                  nxt_link.st = nv_mem_pkg::st_mack;
                  nxt_link.oe = 1'b0;
               end else if (scl_fall) begin
                  nxt_link.sh = {link_ff.sh[6:0], 1'b0};
                  nxt_link.oe = ~link_ff.sh[6]; // [RULE7]
               end
            end
            nv_mem_pkg::st_mack: begin
               if (scl_rise) begin
                  if (link_ff.sda_s || !fifo_in_ready) begin
                     nxt_link.st = nv_mem_pkg::st_idle; // [RULE16]
                  end else begin
                     nxt_link.push = 1'b1;
                     nxt_link.cmd.rd = 1'b1;
                     nxt_link.cmd.addr = {link_ff.bank, link_ff.addr};
                     nxt_link.cmd.data = 8'h00;
                     do_inc = 1'b1;
                  end
               end else if (scl_fall) begin
                  nxt_link.st = nv_mem_pkg::st_tx;
                  nxt_link.cnt = 4'h0;
                  nxt_link.sh = link_ff.rd_buf;
                  nxt_link.oe = ~link_ff.rd_buf[7]; // [RULE16]
               end
            end
            default: begin
               nxt_link.oe = 1'b0;
            end
         endcase
      end
      // The bank bit is held apart, so the count wraps inside its bank.
      if (do_inc) begin
         nxt_link.addr = link_ff.addr + 1'b1; // [RULE15]
      end
   end

   // Power-on reset is the only reset of the link engine. [RULE12]
   always_ff @(posedge link_clk or negedge rstn) begin
      if (!rstn) begin
         link_ff <= nv_mem_pkg::LINK_RESET;
      end else begin
         link_ff <= nxt_link;
      end
   end

   assign sda_oe = link_ff.oe;
   assign sda_out = link_ff.drv;

   // ***************************************************************
   // Command FIFO between the link and system domains
   // ***************************************************************
   nv_async_fifo #(
      .WIDTH($bits(nv_mem_pkg::mem_cmd_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_cmd_fifo (
      .wr_clk(link_clk),
      .rd_clk(clk_sys),
      .rstn(rstn),
      .in_valid(link_ff.push),
      .in_ready(fifo_in_ready),
      .in_data(link_ff.cmd),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // ***************************************************************
   // System domain array access
   // ***************************************************************
   assign fifo_out_ready = ~sys_ff.pend & ~sys_ff.fetch;
   assign pop = fifo_out_valid & fifo_out_ready;

   // Writes land one cycle after pop; a read stalls the FIFO until its reply toggles.
   always_comb begin
      nxt_sys = sys_ff;
      nxt_sys.wp_m = write_protect;
      nxt_sys.wp_s = sys_ff.wp_m;
      nxt_sys.we = pop & ~fifo_out_data.rd & ~sys_ff.wp_s; // [RULE5] [RULE6]
      nxt_sys.pend = pop & fifo_out_data.rd;
      nxt_sys.fetch = sys_ff.pend;
      if (pop) begin
         nxt_sys.wcmd = fifo_out_data;
      end
      if (sys_ff.fetch) begin
         nxt_sys.rd_data = mem_q;
         nxt_sys.rd_tgl = ~sys_ff.rd_tgl;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sys_ff <= nv_mem_pkg::SYS_RESET;
      end else begin
         sys_ff <= nxt_sys;
      end
   end

   // Array port; the read waits a cycle so an earlier write is already stored.
   always_ff @(posedge clk_sys) begin
      if (sys_ff.we) begin
         mem_array[sys_ff.wcmd.addr] <= sys_ff.wcmd.data; // [RULE1]
      end
      mem_q <= mem_array[sys_ff.wcmd.addr];
   end

   // ***************************************************************
   // Checks
   // ***************************************************************
   chk_oe_after_fall: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE7]
      $rose(link_ff.oe) |-> $past(scl_fall))
      else $error("Data line pulled low without a falling clock edge.");

   chk_bit_capture: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE8]
      (link_ff.st == nv_mem_pkg::st_rx && scl_rise && !stop_seen) |=>
      link_ff.sh[0] == $past(link_ff.sda_s))
      else $error("Received bit not taken on the rising edge.");

   chk_open_drain: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE9]
      link_ff.oe |-> !sda_out)
      else $error("Data line driven high.");

   chk_sel_mismatch: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE4] [RULE17]
      (link_ff.st == nv_mem_pkg::st_rx && link_ff.ph == nv_mem_pkg::ph_sel && byte_end &&
      !sel_match && !start_seen && !stop_seen) |=> (!link_ff.oe && link_ff.st == nv_mem_pkg::st_idle)[*2])
      else $error("Mismatched selection byte was acknowledged.");

   chk_upper_addr: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE14]
      (link_ff.st == nv_mem_pkg::st_rx && link_ff.ph == nv_mem_pkg::ph_hi && byte_end &&
      !start_seen && !stop_seen) |=> link_ff.addr[14:8] == $past(link_ff.sh[6:0]))
      else $error("Upper address byte not latched.");

   chk_addr_wrap: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE15]
      do_inc |=> (link_ff.addr == 15'($past(link_ff.addr) + 1'b1)) &&
      (link_ff.cmd.addr[nv_mem_pkg::ADDR_W-1] == link_ff.bank))
      else $error("Address increment left its bank.");

   chk_master_nack: assert property (@(posedge link_clk) disable iff (!rstn) // [RULE16]
      (link_ff.st == nv_mem_pkg::st_mack && scl_rise && link_ff.sda_s && !stop_seen) |=>
      link_ff.st == nv_mem_pkg::st_idle ##1 !link_ff.oe)
      else $error("Read continued after missing acknowledge.");

   chk_wp_block: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE5]
      (pop && !fifo_out_data.rd && sys_ff.wp_s) |=> !sys_ff.we)
      else $error("Write reached the array while protected.");

   chk_wp_allow: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE6] [RULE10]
      (pop && !fifo_out_data.rd && !sys_ff.wp_s) |=> sys_ff.we)
      else $error("Unprotected write was not committed.");

   chk_read_reply: assert property (@(posedge clk_sys) disable iff (!rstn) // [RULE1]
      (pop && fifo_out_data.rd) |-> ##3 $changed(sys_ff.rd_tgl))
      else $error("Read reply not returned in three cycles.");
endmodule

`default_nettype wire

/* File: sim/bus_master_model.sv */
// Purpose: Two-wire bus master model that drives the memory slave.
// Assumes: Open-drain data line with a pull-up; 1 MHz serial clock.
// Notes: The serial clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   output var logic scl,
   output var logic pull_low,
   input wire logic sda,
   output var logic got_tgl,
   output var logic got_kind,
   output var logic [7:0] got_val,
   output var logic viol
);
   // ***************************************************************
   // Bus tasks
   // ***************************************************************
   localparam realtime Q = 250.0;
   // The bus starts idle with both lines released.
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
      got_tgl = 1'b0;
      got_kind = 1'b0;
      got_val = 8'h00;
      viol = 1'b0;
   end
   // Data moves in the low phase and must hold through the high phase.
   task automatic bit_io(input logic b, output logic s);
      #Q pull_low = ~b;
      #Q scl = 1'b1;
      #Q s = sda;
      #Q viol = viol | (sda !== s);
      scl = 1'b0;
   endtask
   task automatic start();
      #Q pull_low = 1'b0;
      #Q scl = 1'b1;
      #Q pull_low = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q pull_low = 1'b1;
      #Q scl = 1'b1;
      #Q pull_low = 1'b0;
      #Q;
   endtask
   task automatic note(input logic k, input logic [7:0] v);
      got_kind = k;
      got_val = v;
      got_tgl = ~got_tgl;
   endtask
   task automatic send(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(v[i], s);
      bit_io(1'b1, s);
      note(1'b0, {7'h00, s});
   endtask
   // The master acknowledges to go on and withholds it after the last byte.
   task automatic recv(input logic mack);
      logic s;
      logic [7:0] v;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         v[i] = s;
      end
      bit_io(~mack, s);
      note(1'b1, v);
   endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the two-wire memory slave.
// Assumes: 250 MHz system clock, 6 ns link clock, model master on the bus.
// Notes: The driver queues expectations; a watcher checks each result.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys, link_clk, rstn, pin_lo, pin_hi, wp;
   logic od_bad = 1'b0;
   logic [7:0] low_d1;
   logic scl, pull_low, got_tgl, got_kind, viol, sda_out, sda_oe, sda;
   logic [7:0] got_val;
   logic [8:0] exp_q[$];
   logic [8:0] e;
   int errors, check_count;
   // Wire with pull-up, low while either party pulls.
   assign sda = ~((sda_oe & ~sda_out) | pull_low);
   two_wire_nv_memory_slave dut (.clk_sys(clk_sys), .rstn(rstn), .link_clk(link_clk),
      .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .device_select_pin_low(pin_lo), .device_select_pin_high(pin_hi), .write_protect(wp));
   bus_master_model m (.scl(scl), .pull_low(pull_low), .sda(sda), .got_tgl(got_tgl),
      .got_kind(got_kind), .got_val(got_val), .viol(viol));
   // ***************************************************************
   // Clocks, checks and bus helpers
   // ***************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Link clock with a phase unrelated to the system clock.
   initial begin
      link_clk = 1'b0;
      #0.5;
      forever #3 link_clk = ~link_clk;
   end
   // The data pin may only be pulled low, never driven high.
   always @(posedge link_clk) if (sda_oe === 1'b1 && sda_out !== 1'b0) od_bad <= 1'b1;
   task automatic cmp_ack(input logic g, input logic x);
      check_count++;
      if (g !== x) begin
         errors++;
         $display("[FAIL] %0t ack level %b expected %b", $time, g, x);
      end
   endtask
   task automatic cmp_data(input logic [7:0] g, input logic [7:0] x);
      check_count++;
      if (g !== x) begin
         errors++;
         $display("[FAIL] %0t read data %h expected %h", $time, g, x);
      end
   endtask
   // Each reported result is matched with the oldest expectation.
   always @(got_tgl) begin
      if (rstn === 1'b1) begin
         e = exp_q.pop_front();
         if (got_kind) cmp_data(got_val, e[7:0]);
         else cmp_ack(got_val[0], e[0]);
      end
   end
   function automatic logic [7:0] sel(input logic b, input logic rd);
      return {nv_mem_pkg::DEV_TYPE_DEFAULT, pin_hi, pin_lo, b, rd};
   endfunction
   task automatic wb(input logic [7:0] v, input logic nak);
      exp_q.push_back({1'b0, 7'h00, nak});
      m.send(v);
   endtask
   task automatic rb(input logic [7:0] v, input logic mack);
      exp_q.push_back({1'b1, v});
      m.recv(mack);
   endtask
   // Point the latch at an address of bank b, then restart as a read when asked.
   task automatic put(input logic b, input logic [7:0] hi, input logic [7:0] lo, input logic rd);
      m.start();
      wb(sel(b, 1'b0), 1'b0);
      wb(hi, 1'b0);
      wb(lo, 1'b0);
      if (rd) m.start();
      if (rd) wb(sel(b, 1'b1), 1'b0);
   endtask
   task automatic wrap_case(input logic b);
      logic [7:0] d0, d1;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      if (!b) low_d1 = d1;
      put(b, 8'hFF, 8'hFF, 1'b0);
      wb(d0, 1'b0);
      wb(d1, 1'b0);
      m.stop();
      @(posedge clk_sys) #1 wp = 1'b1;
      put(b, 8'h7F, 8'hFF, 1'b0);
      wb(~d0, 1'b0);
      m.stop();
      @(posedge clk_sys) #1 wp = 1'b0;
      // The latch now points at 0000, so a bare read of the lower bank must show its own byte.
      m.start();
      wb(sel(1'b0, 1'b1), 1'b0);
      rb(low_d1, 1'b0);
      m.stop();
      put(b, 8'h7F, 8'hFF, 1'b1);
      rb(d0, 1'b1);
      rb(d1, 1'b0);
      m.stop();
      $display("test wrap in bank %0d done", b);
   endtask
   task automatic results();
      if (exp_q.size() != 0) begin
         errors++;
         $display("[FAIL] %0t %0d expected results never seen", $time, exp_q.size());
      end
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ***************************************************************
   // Main sequence and watchdog
   // ***************************************************************
   initial begin
      rstn = 1'b0;
      {pin_hi, pin_lo, wp} = 3'h0;
      errors = 0;
      check_count = 0;
      void'($urandom(11163));
      repeat (2) @(posedge clk_sys);
      #1 cmp_ack(sda_oe, 1'b0);
      rstn = 1'b1;
      {pin_hi, pin_lo} = 2'($urandom);
      #100;
      for (int p = 0; p < 4; p++) begin
         m.start();
         wb({nv_mem_pkg::DEV_TYPE_DEFAULT, 2'(p), 2'h0}, 2'(p) != {pin_hi, pin_lo});
         if (2'(p) != {pin_hi, pin_lo}) wb(8'h00, 1'b1);
         m.stop();
      end
      $display("test select done");
      wrap_case(1'b0);
      wrap_case(1'b1);
      cmp_ack(viol, 1'b0);
      cmp_ack(od_bad, 1'b0);
      results();
   end
   initial begin
      #410000;
      errors++;
      $display("[FAIL] %0t run did not finish", $time);
      results();
   end
endmodule
`default_nettype wire
